// File: src/rgpt_defs.vh
`ifndef RGPT_DEFS_VH
`define RGPT_DEFS_VH
// ****************************************************************
// register byte addresses on apb
// ****************************************************************
`define RGPT_ADDR_W 12
`define RGPT_OFS_BUS_ADDR 12'h000
`define RGPT_OFS_LOCK 12'h004
`define RGPT_OFS_MODE 12'h008
`define RGPT_OFS_PWR_DELAY 12'h00C
`define RGPT_OFS_STATUS 12'h010
`define RGPT_OFS_CMD 12'h014
`define RGPT_OFS_GUARD 12'h018
// ****************************************************************
// reset values
// ****************************************************************
`define RGPT_RST_BUS_ADDR 8'hC0
`define RGPT_RST_LOCK 8'h02
`define RGPT_RST_MODE 8'h00
`define RGPT_RST_PWR_DELAY 8'hFF
`define RGPT_MODE_USED_MASK 8'h03
// ****************************************************************
// status fields
// ****************************************************************
`define RGPT_ST_BUSY 0
`define RGPT_ST_HARD 1
`define RGPT_ST_PENALTY 2
`define RGPT_ST_PWR_DELAY 3
`define RGPT_ST_GUARD 4
`define RGPT_ST_CMD_ACTIVE 5
// ****************************************************************
// command event codes, written to the command register
// ****************************************************************
`define RGPT_EV_FW_CHECK_OK 4'h1
`define RGPT_EV_FW_CHECK_FAIL 4'h2
`define RGPT_EV_FW_CHECK_DIS 4'h3
`define RGPT_EV_SESSION_OPEN 4'h4
`define RGPT_EV_REPLY_OK 4'h5
`define RGPT_EV_REPLY_FAIL 4'h6
`define RGPT_EV_AUTH1 4'h7
`define RGPT_EV_AUTH2_OK 4'h8
`define RGPT_EV_AUTH2_FAIL 4'h9
`define RGPT_EV_ENC2_FAIL 4'hA
`define RGPT_EV_BAD_ORDINAL 4'hB
`define RGPT_EV_OTHER 4'hC
`define RGPT_EV_DONE 4'hF
// ****************************************************************
// timing
// ****************************************************************
`define RGPT_CLK_MHZ 125
`define RGPT_TICK_US 1
`define RGPT_TICK_CYC (`RGPT_CLK_MHZ * `RGPT_TICK_US)
`define RGPT_PENALTY_BASE_MS 262
`define RGPT_PENALTY_MAX_MS 32000
`define RGPT_US_PER_MS 1000
`endif

// File: src/rgpt_reset_guard.v
`timescale 1ns/1ps
`include "rgpt_defs.vh"
// Summary of operation
// [R01] supply detector holds device in reset
// [R02] internal clock; bus pins glitch filtered
// [R03] reset clears guard flag, starts tick counter
// [R04] expiry restores flag, after running command
// [R05] after restore, guard logic idles until reset
// [R06] flag zero at reset: ignore commands interval
// [R07] delay end sets flag, commands resume
// [R08] reset during delay restarts fresh interval
// [R09] power delay byte selects interval
// [R10] guard works same locked or unlocked
// [R11] hard lockout refuses, reports, asserts busy
// [R12] wrong session order causes hard lockout
// [R13] check or reply failure causes lockout
// [R14] penalty: no commands, status shows error
// [R15] penalties only while device locked
// [R16] locked failures start a penalty delay
// [R17] penalty starts 262ms, then doubles
// [R18] capped at power delay and 32s
// [R19] mode upper bits programmed zero externally
// [R20] digest reference programmed before locking
// [R21] bus address byte ships as C0
// [R22] lock byte ships with low bits 10
// [R23] hash constant permanently write protected
// [R24] penalty uses same 1 MHz tick
module rgpt_reset_guard #(
  parameter TICK_W = 27
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_supply_fault,
  input wire i_nv_guard_flag,
  input wire i_scl,
  input wire i_sda,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`RGPT_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_busy,
  output reg o_cmd_accept,
  output reg o_nv_guard_wr,
  output reg o_nv_guard_val,
  output reg o_scl_clean,
  output reg o_sda_clean,
  output reg o_hash_wr_en
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam G_START = 2'd0;
  localparam G_ARMED = 2'd1;
  localparam G_DELAY = 2'd2;
  localparam G_IDLE = 2'd3;
  localparam Q_FIRST = 2'd0;
  localparam Q_AFTER_CHECK = 2'd1;
  localparam Q_AFTER_OPEN = 2'd2;
  localparam Q_OPEN = 2'd3;

  // ****************************************************************
  // internal reset: pin reset or supply detector
  // ****************************************************************
  reg [2:0] flt_sync;
  wire rst_n_int;
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flt_sync <= 3'b111;
    end else begin
      flt_sync <= {flt_sync[1:0], i_supply_fault};
    end
  end
  // asserting fault resets asynchronously; release waits for clear
  assign rst_n_int = i_reset_n & ~i_supply_fault & ~flt_sync[2]; // R01

  // ****************************************************************
  // pin filters: three stages, change counts once 2 and 3 agree
  // ****************************************************************
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  always @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      o_scl_clean <= 1'b1;
      o_sda_clean <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
      if (scl_s[1] == scl_s[2]) begin
        o_scl_clean <= scl_s[2]; // R02
      end
      if (sda_s[1] == sda_s[2]) begin
        o_sda_clean <= sda_s[2]; // R02
      end
    end
  end

  // ****************************************************************
  // 1 MHz tick shared by both delay counters
  // ****************************************************************
  localparam [7:0] TICK_LAST = `RGPT_TICK_CYC - 1;
  reg [7:0] pre_cnt;
  reg tick;
  always @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pre_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (pre_cnt == TICK_LAST);
      pre_cnt <= (pre_cnt == TICK_LAST) ? 8'h00 : pre_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] bus_address_byte;
  reg [7:0] lock_control_byte;
  reg [7:0] operating_mode_byte;
  reg [7:0] power_delay_code;
  reg [3:0] last_event;
  reg cmd_active;
  reg [1:0] g_state;
  reg reset_guard_flag;
  reg [TICK_W-1:0] g_cnt;
  reg hard_lockout_error;
  reg timed_penalty_error;
  reg [TICK_W-1:0] p_cnt;
  reg [TICK_W-1:0] p_len;
  reg [1:0] q_state;
  reg check_used;
  reg open_used;
  reg auth1_pending;
  wire locked = (lock_control_byte[1:0] != 2'b00);

  // interval in 1 MHz ticks per power delay code
  function [TICK_W-1:0] pwr_ticks;
    input [7:0] code;
    begin
      case (code)
        8'h00: pwr_ticks = 262000; // R09
        8'h01: pwr_ticks = 524000;
        8'h02: pwr_ticks = 785000;
        8'h04: pwr_ticks = 1300000;
        8'h08: pwr_ticks = 2400000;
        8'h10: pwr_ticks = 4500000;
        8'h20: pwr_ticks = 8700000;
        8'h40: pwr_ticks = 17000000;
        8'h80: pwr_ticks = 34000000;
        // other codes are unpredictable; the longest is the safe pick
        default: pwr_ticks = 67000000;
      endcase
    end
  endfunction
  wire [TICK_W-1:0] pwr_len = pwr_ticks(power_delay_code);
  localparam [TICK_W-1:0] PEN_BASE = `RGPT_PENALTY_BASE_MS * `RGPT_US_PER_MS;
  localparam [TICK_W-1:0] PEN_MAX = `RGPT_PENALTY_MAX_MS * `RGPT_US_PER_MS;
  wire in_pwr_delay = (g_state == G_DELAY);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire acc = i_psel & i_penable & ~o_pready;
  wire wr = acc & i_pwrite;
  wire cmd_wr = wr & (i_paddr == `RGPT_OFS_CMD);
  wire [3:0] ev = i_pwdata[3:0];
  // commands are refused while any delay or lockout stands
  wire blocked = in_pwr_delay | (g_state == G_START) | hard_lockout_error | timed_penalty_error;
  wire ev_go = cmd_wr & ~blocked & (ev != `RGPT_EV_DONE);
  wire ev_done = cmd_wr & (ev == `RGPT_EV_DONE);

  // ****************************************************************
  // command ordering and failure classification
  // ****************************************************************
  reg hard_hit;
  reg pen_hit;
  reg [1:0] next_q;
  always @* begin
    hard_hit = 1'b0;
    pen_hit = 1'b0;
    next_q = q_state;
    if (locked) begin
      case (q_state)
        Q_FIRST, Q_AFTER_CHECK: begin
          if (ev == `RGPT_EV_SESSION_OPEN) begin
            next_q = Q_AFTER_OPEN;
          end else if ((ev == `RGPT_EV_FW_CHECK_OK || ev == `RGPT_EV_FW_CHECK_DIS) &&
                       !check_used) begin
            next_q = Q_AFTER_CHECK;
          end else begin
            hard_hit = 1'b1; // R12 R13
          end
        end
        Q_AFTER_OPEN: begin
          if (ev == `RGPT_EV_REPLY_OK) begin
            next_q = Q_OPEN;
          end else begin
            hard_hit = 1'b1; // R12 R13
          end
        end
        default: begin
          if (ev == `RGPT_EV_REPLY_OK || ev == `RGPT_EV_REPLY_FAIL) begin
            hard_hit = 1'b1; // R12
          end else if (ev == `RGPT_EV_FW_CHECK_OK || ev == `RGPT_EV_FW_CHECK_FAIL ||
                       ev == `RGPT_EV_FW_CHECK_DIS) begin
            hard_hit = 1'b1; // R13
          end else if (ev == `RGPT_EV_SESSION_OPEN && open_used) begin
            pen_hit = 1'b1; // R16
          end else if (auth1_pending && ev != `RGPT_EV_AUTH2_OK) begin
            pen_hit = 1'b1; // R16
          end else if (ev == `RGPT_EV_AUTH2_FAIL || ev == `RGPT_EV_ENC2_FAIL ||
                       ev == `RGPT_EV_BAD_ORDINAL) begin
            pen_hit = 1'b1; // R16
          end
        end
      endcase
    end
  end

  always @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      q_state <= Q_FIRST;
      check_used <= 1'b0;
      open_used <= 1'b0;
      auth1_pending <= 1'b0;
      hard_lockout_error <= 1'b0;
      timed_penalty_error <= 1'b0;
      p_cnt <= {TICK_W{1'b0}};
      p_len <= {TICK_W{1'b0}};
      cmd_active <= 1'b0;
      last_event <= 4'h0;
    end else begin
      if (ev_go) begin
        last_event <= ev;
        cmd_active <= 1'b1;
        q_state <= hard_hit ? q_state : next_q;
        if (ev == `RGPT_EV_FW_CHECK_OK || ev == `RGPT_EV_FW_CHECK_FAIL ||
            ev == `RGPT_EV_FW_CHECK_DIS || ev == `RGPT_EV_SESSION_OPEN) begin
          check_used <= 1'b1;
        end
        if (ev == `RGPT_EV_SESSION_OPEN) begin
          open_used <= 1'b1;
        end
        auth1_pending <= (ev == `RGPT_EV_AUTH1);
        if (hard_hit) begin
          hard_lockout_error <= 1'b1; // R11
        end
        if (pen_hit && locked) begin
          // R15 R17 R18: first 262 ms, then double, capped
          timed_penalty_error <= 1'b1; // R14
          p_cnt <= {TICK_W{1'b0}};
          if (p_len == {TICK_W{1'b0}}) begin
            p_len <= (PEN_BASE >= pwr_len) ? pwr_len : PEN_BASE; // R17
          end else if ((p_len << 1) >= pwr_len) begin
            p_len <= pwr_len; // R18
          end else begin
            p_len <= p_len << 1; // R17
          end
        end
      end else if (ev_done) begin
        cmd_active <= 1'b0;
      end
      if (timed_penalty_error && tick) begin
        p_cnt <= p_cnt + {{(TICK_W-1){1'b0}}, 1'b1}; // R24
        if (p_cnt + {{(TICK_W-1){1'b0}}, 1'b1} >= ((p_len > PEN_MAX) ? PEN_MAX : p_len)) begin
          timed_penalty_error <= 1'b0; // R18
        end
      end
    end
  end

  // ****************************************************************
  // reset guard and power delay
  // ****************************************************************
  always @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      g_state <= G_START;
      g_cnt <= {TICK_W{1'b0}};
      reset_guard_flag <= 1'b1;
      o_nv_guard_wr <= 1'b0;
      o_nv_guard_val <= 1'b0;
    end else begin
      o_nv_guard_wr <= 1'b0;
      // same path regardless of lock state
      case (g_state) // R10
        G_START: begin
          reset_guard_flag <= 1'b0;
          o_nv_guard_wr <= 1'b1; // R03
          o_nv_guard_val <= 1'b0;
          g_state <= i_nv_guard_flag ? G_ARMED : G_DELAY; // R06
        end
        G_ARMED, G_DELAY: begin
          if (g_cnt >= pwr_len) begin
            if (!cmd_active || g_state == G_DELAY) begin
              reset_guard_flag <= 1'b1; // R04 R07
              o_nv_guard_wr <= 1'b1;
              o_nv_guard_val <= 1'b1;
              g_state <= G_IDLE;
            end
          end else if (tick) begin
            g_cnt <= g_cnt + {{(TICK_W-1){1'b0}}, 1'b1}; // R03 R08
          end
        end
        default: g_state <= G_IDLE; // R05
      endcase
    end
  end

  // ****************************************************************
  // configuration bytes and bus
  // ****************************************************************
  always @(posedge i_sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      bus_address_byte <= `RGPT_RST_BUS_ADDR; // R21
      lock_control_byte <= `RGPT_RST_LOCK; // R22
      operating_mode_byte <= `RGPT_RST_MODE;
      power_delay_code <= `RGPT_RST_PWR_DELAY;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      o_busy <= 1'b1;
      o_cmd_accept <= 1'b0;
      o_hash_wr_en <= 1'b0;
    end else begin
      o_pready <= acc;
      o_pslverr <= 1'b0;
      o_hash_wr_en <= 1'b0; // R23
      o_busy <= blocked | cmd_active; // R11 R14
      o_cmd_accept <= ev_go; // R06
      if (wr) begin
        if (i_paddr == `RGPT_OFS_BUS_ADDR) begin
          bus_address_byte <= i_pwdata[7:0];
        end else if (i_paddr == `RGPT_OFS_LOCK) begin
          lock_control_byte <= i_pwdata[7:0];
        end else if (i_paddr == `RGPT_OFS_MODE) begin
          operating_mode_byte <= i_pwdata[7:0];
        end else if (i_paddr == `RGPT_OFS_PWR_DELAY) begin
          power_delay_code <= i_pwdata[7:0];
        end else if (i_paddr != `RGPT_OFS_CMD) begin
          o_pslverr <= 1'b1;
        end
      end else if (acc) begin
        o_prdata <= 32'h00000000;
        if (i_paddr == `RGPT_OFS_BUS_ADDR) begin
          o_prdata <= {24'h000000, bus_address_byte};
        end else if (i_paddr == `RGPT_OFS_LOCK) begin
          o_prdata <= {24'h000000, lock_control_byte};
        end else if (i_paddr == `RGPT_OFS_MODE) begin
          o_prdata <= {24'h000000, operating_mode_byte};
        end else if (i_paddr == `RGPT_OFS_PWR_DELAY) begin
          o_prdata <= {24'h000000, power_delay_code};
        end else if (i_paddr == `RGPT_OFS_STATUS) begin
          o_prdata <= {26'h0000000, cmd_active, reset_guard_flag, in_pwr_delay,
                       timed_penalty_error, hard_lockout_error, blocked | cmd_active}; // R14
        end else if (i_paddr == `RGPT_OFS_CMD) begin
          o_prdata <= {28'h0000000, last_event};
        end else if (i_paddr == `RGPT_OFS_GUARD) begin
          o_prdata <= {{(32-TICK_W){1'b0}}, g_cnt};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// File: tb/rgpt_reset_guard_monitor.sv
`timescale 1ns/1ps
`include "rgpt_defs.vh"
module rgpt_reset_guard_monitor (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_supply_fault,
  input wire i_nv_guard_flag,
  input wire i_scl,
  input wire i_sda,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`RGPT_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_busy,
  input wire o_cmd_accept,
  input wire o_nv_guard_wr,
  input wire o_nv_guard_val,
  input wire o_scl_clean,
  input wire o_sda_clean,
  input wire o_hash_wr_en
);
  // ****************
  // helpers
  // ****************
  reg [1:0] wr_cnt;
  wire take = i_psel && i_penable && !o_pready;
  wire cmd_take = take && i_pwrite && i_paddr == `RGPT_OFS_CMD;
  // supply fault is a reset too, so it restarts the count of flag writes
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_cnt <= 2'h0;
    end else if (i_supply_fault) begin
      wr_cnt <= 2'h0;
    end else if (o_nv_guard_wr && wr_cnt != 2'h3) begin
      wr_cnt <= wr_cnt + 2'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  property p_hash; !o_hash_wr_en; endproperty
  a_hash: assert property (p_hash) else $error("hash write enable raised");
  property p_answer; take |=> o_pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_clear; $rose(i_reset_n) && !i_supply_fault |->
    ##[0:4] (o_nv_guard_wr && !o_nv_guard_val); endproperty
  a_clear: assert property (p_clear) else $error("guard flag not cleared");
  property p_fault; i_supply_fault |=> o_busy [*3]; endproperty
  a_fault: assert property (p_fault) else $error("busy low in supply fault");
  property p_once; wr_cnt <= 2'h2; endproperty
  a_once: assert property (p_once) else $error("extra guard flag writes");
  property p_filt; $changed(o_scl_clean) |-> $past(i_scl, 3) == o_scl_clean; endproperty
  a_filt: assert property (p_filt) else $error("clock pin glitch passed");
  property p_acc; o_cmd_accept |-> $past(cmd_take) || $past(cmd_take, 2); endproperty
  a_acc: assert property (p_acc) else $error("accept without command");
  c_acc: cover property (o_cmd_accept);
  c_err: cover property (o_pslverr);
  c_clr: cover property (o_nv_guard_wr);
endmodule
bind rgpt_reset_guard rgpt_reset_guard_monitor mon_u (.i_sys_clk, .i_reset_n,
  .i_supply_fault, .i_nv_guard_flag, .i_scl, .i_sda, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_busy, .o_cmd_accept,
  .o_nv_guard_wr, .o_nv_guard_val, .o_scl_clean, .o_sda_clean, .o_hash_wr_en);

// File: tb/rgpt_host_link_model.sv
`timescale 1ns/1ps
module rgpt_host_link_model (
  input wire i_frame,
  input wire i_glitch,
  output reg o_scl,
  output reg o_sda
);
  reg [7:0] pat;
  // link clock stands still outside frames; both lines idle high by pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    pat = 8'hA5;
    #3;
    forever begin
      #40;
      if (i_frame) begin
        o_scl = ~o_scl;
        if (!o_scl) begin
          o_sda = pat[7];
          pat = {pat[6:0], pat[7]};
        end
      end else if (!i_glitch) begin
        o_scl = 1'b1;
        o_sda = 1'b1;
      end
    end
  end
  // low across exactly one sampling edge: the filter must swallow it
  always @(posedge i_glitch) begin
    #2 o_scl = 1'b0;
    #8 o_scl = 1'b1;
  end
endmodule

// File: tb/rgpt_reset_guard_tb.sv
`timescale 1ns/1ps
`include "rgpt_defs.vh"
module rgpt_reset_guard_tb;
  // ****************
  // bench
  // ****************
  localparam [15*17-1:0] SEQ = {17'h1C000, 17'h14C00, 17'h15000, 17'h12000, 17'h11000,
    17'h16000, 17'h13450, 17'h145B0, 17'h14540, 17'h1457C, 17'h14579, 17'h145A0,
    17'h14578, 17'h0BBB0, 17'h04C00};
  reg i_sys_clk = 1'b0, i_reset_n = 1'b0, i_supply_fault = 1'b0, nv = 1'b1, nv_seed = 1'b1;
  reg i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, frame = 1'b0, glitch = 1'b0;
  reg [11:0] i_paddr = 12'h000;
  reg [31:0] i_pwdata = 32'h0, rd, rng = 32'h00005D4B;
  reg er;
  reg [16:0] e;
  reg [1:0] f;
  wire scl, sda, o_pready, o_pslverr, o_busy, o_cmd_accept, o_nv_guard_wr, o_nv_guard_val;
  wire o_scl_clean, o_sda_clean, o_hash_wr_en;
  wire [31:0] o_prdata;
  integer num_errors = 0, checks_done = 0, acc = 0, gwr = 0, edges = 0, i, k, n0, t0;
  integer sedges = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  // stands in for the stored flag cell
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) nv <= nv_seed;
    else if (o_nv_guard_wr) nv <= o_nv_guard_val;
    acc <= acc + o_cmd_accept;
    gwr <= gwr + o_nv_guard_wr;
  end
  always @(o_scl_clean) edges = edges + 1;
  always @(o_sda_clean) sedges = sedges + 1;
  rgpt_reset_guard dut_u (.i_sys_clk, .i_reset_n, .i_supply_fault, .i_nv_guard_flag(nv),
    .i_scl(scl), .i_sda(sda), .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .o_busy, .o_cmd_accept, .o_nv_guard_wr,
    .o_nv_guard_val, .o_scl_clean, .o_sda_clean, .o_hash_wr_en);
  rgpt_host_link_model host_u (.i_frame(frame), .i_glitch(glitch), .o_scl(scl), .o_sda(sda));
  function [31:0] xs;
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      xs = rng;
    end
  endfunction
  // {penalty, lockout} after the event codes of e, oldest in the top nibble
  function [1:0] fate(input [16:0] s);
    reg [3:0] c, p;
    reg ok;
    integer j;
    begin
      fate = 2'b00;
      p = 4'h0;
      ok = 1'b0;
      for (j = 3; j >= 0; j = j - 1) begin
        c = s[j*4+:4];
        if (c != 4'h0 && s[16] && fate == 2'b00) begin
          if (!ok) begin
            if (c == 4'h5 && p == 4'h4) ok = 1'b1;
            else if (!((c == 4'h1 || c == 4'h3) && p == 4'h0) && !(c == 4'h4 && p != 4'h4))
              fate = 2'b01;
          end else if (c == 4'h4 || c > 4'h8 && c < 4'hC || p == 4'h7 && c != 4'h8)
            fate = 2'b10;
          p = c;
        end
      end
    end
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      do begin
        @(posedge i_sys_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask
  // the flag value stands for how the previous run ended
  task rst(input fl);
    begin
      @(posedge i_sys_clk);
      i_reset_n <= 1'b0;
      nv_seed <= fl;
      repeat (12) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors = num_errors + 1;
    finish_test;
  end
  initial begin
    rst(1'b1);
    apb(0, `RGPT_OFS_BUS_ADDR, 0);
    chk("bus address", rd, 32'hC0);
    apb(0, `RGPT_OFS_LOCK, 0);
    chk("lock low bits", rd[1:0], 2'b10);
    apb(1, `RGPT_OFS_MODE, 32'h3);
    apb(0, `RGPT_OFS_MODE, 0);
    chk("mode", rd, 32'h3);
    apb(0, 12'h01C, 0);
    chk("unmapped error", er, 1'b1);
    for (i = 0; i < 21; i = i + 1) begin
      e = i < 15 ? SEQ[i*17+:17] : {xs() % 2 == 0, 8'h45, 4'(xs() % 6 + 7), 4'(xs() % 6 + 7)};
      rst(1'b1);
      if (!e[16]) apb(1, `RGPT_OFS_LOCK, 0);
      for (k = 3; k >= 0; k = k - 1) begin
        if (e[k*4+:4] != 4'h0) begin
          apb(1, `RGPT_OFS_CMD, {28'h0, e[k*4+:4]});
          apb(1, `RGPT_OFS_CMD, {28'h0, `RGPT_EV_DONE});
        end
      end
      f = fate(e);
      apb(0, `RGPT_OFS_STATUS, 0);
      chk("status", rd[2:0], {f, |f});
      n0 = acc;
      apb(1, `RGPT_OFS_CMD, {28'h0, `RGPT_EV_OTHER});
      @(posedge i_sys_clk);
      chk("refused command", acc - n0, f == 2'b00);
    end
    n0 = gwr;
    rst(1'b0);
    repeat (4) @(posedge i_sys_clk);
    chk("clear writes", gwr - n0, 1);
    apb(0, `RGPT_OFS_STATUS, 0);
    chk("power delay status", rd[4:0], 5'h09);
    n0 = acc;
    apb(1, `RGPT_OFS_CMD, {28'h0, `RGPT_EV_FW_CHECK_OK});
    @(posedge i_sys_clk);
    chk("ignored in delay", acc - n0, 0);
    apb(0, `RGPT_OFS_GUARD, 0);
    t0 = rd;
    repeat (1246) @(posedge i_sys_clk);
    apb(0, `RGPT_OFS_GUARD, 0);
    chk("tick count", rd - t0, 1250 / `RGPT_TICK_CYC);
    rst(1'b0);
    apb(0, `RGPT_OFS_GUARD, 0);
    chk("restart", rd < 2, 1);
    rst(1'b1);
    repeat (5) @(posedge i_sys_clk);
    i_supply_fault <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("fault busy", o_busy, 1'b1);
    n0 = gwr;
    i_supply_fault <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk("fault release", gwr - n0, 1);
    apb(0, `RGPT_OFS_STATUS, 0);
    chk("fault delay", rd[3], 1'b1);
    n0 = edges;
    glitch <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    chk("glitch", o_scl_clean, 1'b1);
    chk("glitch edges", edges - n0, 0);
    glitch <= 1'b0;
    n0 = edges;
    t0 = sedges;
    frame <= 1'b1;
    repeat (200) @(posedge i_sys_clk);
    frame <= 1'b0;
    repeat (30) @(posedge i_sys_clk);
    chk("clean follows", edges - n0 > 2 && o_scl_clean === 1'b1, 1);
    chk("data follows", sedges - t0 > 2, 1);
    finish_test;
  end
endmodule
